// >>> spbic_map.svh
// Function
// - Sine 5-50 kHz from 32x9 pattern memory
// - Sine period equals M system clocks
// - Sample counter steps every N clocks
// - Half-cycle pattern fetched from 40H-7FH
// - Low byte even address, bit 8 odd
// - CPU pattern access blocked while enabled
// - Samples delivered in order to 10-bit DAC
// - sine_enable bit 7; clear powers down DAC
// - bias_divider_enable bit 4 powers bias divider
// - Divider N equals field plus one
// - half_cycle_samples equals field plus one
// - amp_disable_n bit 7 low enables amplifiers
// - Gain codes 1-10 select gain, others unity
// - Switch bit n closes meas switch n
// - Reference DAC code passed to analog DAC
// - peak_filter_enable powers comparator and PMOS
// - Filter bits 1,0 drive discharge switches
// - Unimplemented bits read zero
`ifndef SPBIC_MAP_SVH
`define SPBIC_MAP_SVH

`define SPBIC_OFS_SINE_GEN_CTRL 12'h000
`define SPBIC_OFS_SINE_DIVIDER_N 12'h004
`define SPBIC_OFS_HALF_CYCLE_COUNT 12'h008
`define SPBIC_OFS_AMP_CTRL 12'h00C
`define SPBIC_OFS_SWITCH_CTRL 12'h010
`define SPBIC_OFS_REF_DAC_CODE 12'h014
`define SPBIC_OFS_FILTER_CTRL 12'h018
`define SPBIC_PAT_WIN_PAGE 4'h1
`define SPBIC_PAT_FIRST 8'h40
`define SPBIC_PAT_LAST 8'h7F

`define SPBIC_MASK_SINE_GEN_CTRL 8'h90
`define SPBIC_MASK_SINE_DIVIDER_N 8'h3F
`define SPBIC_MASK_HALF_CYCLE_COUNT 8'h1F
`define SPBIC_MASK_AMP_CTRL 8'h8F
`define SPBIC_MASK_SWITCH_CTRL 8'hFF
`define SPBIC_MASK_REF_DAC_CODE 8'h3F
`define SPBIC_MASK_FILTER_CTRL 8'h83
`define SPBIC_RST_REG 8'h00

`define SPBIC_BIT_SINE_EN 7
`define SPBIC_BIT_BIAS_EN 4
`define SPBIC_BIT_AMP_DIS_N 7
`define SPBIC_BIT_FILT_EN 7
`define SPBIC_BIT_DISCH_B 1
`define SPBIC_BIT_DISCH_A 0

`define SPBIC_GAIN_MAX 4'hA
`define SPBIC_GAIN_UNITY 4'h0
`define SPBIC_DAC_MID 10'h200
`define SPBIC_DAC_MIRROR 10'h1FF

`endif

// >>> spbic_pkg.sv
`default_nettype none
package spbic_pkg;

    typedef struct packed {
        logic read;
        logic write;
        logic [11:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } spbic_avm_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } spbic_avm_rsp_t;

    typedef struct packed {
        logic [7:0] sine_gen_ctrl;
        logic [7:0] sine_divider_n;
        logic [7:0] half_cycle_count;
        logic [7:0] amp_ctrl;
        logic [7:0] switch_ctrl;
        logic [7:0] ref_dac_code;
        logic [7:0] filter_ctrl;
    } spbic_regs_t;

    typedef struct packed {
        logic sine_buffer_amp_en;
        logic sine_dac_en;
        logic bias_divider_en;
        logic meas_amp_a_en;
        logic diff_amp_en;
        logic ref_dac_en;
        logic [3:0] diff_gain_sel;
        logic [5:0] ref_dac_level;
        logic [7:0] meas_switches;
        logic peak_comparator_en;
        logic peak_pmos_en;
        logic discharge_switch_a;
        logic discharge_switch_b;
    } spbic_analog_t;

    typedef enum logic [1:0] {
        SPBIC_GEN_IDLE = 2'b00,
        SPBIC_GEN_RUN = 2'b01
    } spbic_gen_st_t;

endpackage
`default_nettype wire

// >>> spbic_pattern_ram.sv
`timescale 1ns/1ps
`default_nettype none
module spbic_pattern_ram #(
    parameter int AW = 6,
    parameter int DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [7:0] rd_data_a,
    output logic [7:0] rd_data_b
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } spbic_ram_st_t;

    spbic_ram_st_t q;
    spbic_ram_st_t d;

    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("pattern memory depth must be two to the address width");
    end

    always_comb begin
        d = q;
        if (wr_en) begin
            d.mem[wr_addr] = wr_data;
        end
    end

    // Cleared at reset so a never-loaded pattern plays codes 512 then 511 around mid-scale
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_data_a = q.mem[rd_addr_a];
    assign rd_data_b = q.mem[rd_addr_b];
endmodule // spbic_pattern_ram
`default_nettype wire

// >>> spbic_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spbic_map.svh"
module spbic_top #(
    parameter int DIV_W = 6,
    parameter int LEN_W = 5
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire spbic_pkg::spbic_avm_req_t avm_req,
    output spbic_pkg::spbic_avm_rsp_t avm_rsp,
    output spbic_pkg::spbic_analog_t analog_ctrl,
    output logic [9:0] sine_dac_code,
    output logic sample_strobe
);
    localparam int IDX_W = LEN_W + 1;
    // Span of the shared region that holds the half-cycle pattern
    localparam int PAT_SPAN = `SPBIC_PAT_LAST - `SPBIC_PAT_FIRST + 1;

    if (DIV_W < 1 || DIV_W > 6) begin : g_bad_div
        $error("divider field width must be 1 to 6");
    end
    if (LEN_W < 1 || LEN_W > 5) begin : g_bad_len
        $error("half-cycle field width must be 1 to 5");
    end
    // Two bytes per sample, so the region must cover every index
    if (PAT_SPAN < (1 << IDX_W)) begin : g_bad_span
        $error("pattern region too small for the half-cycle length");
    end

    // Whole state in one word: bus answer, registers and generator
    typedef struct packed {
        spbic_pkg::spbic_regs_t regs;
        spbic_pkg::spbic_gen_st_t gen;
        logic [DIV_W-1:0] div_cnt;
        logic [IDX_W-1:0] idx;
        logic [9:0] dac;
        logic stb;
        logic ack;
        logic [31:0] rdata;
    } spbic_top_st_t;

    localparam spbic_top_st_t ST_RST = '{
        regs: '{
            sine_gen_ctrl: `SPBIC_RST_REG,
            sine_divider_n: `SPBIC_RST_REG,
            half_cycle_count: `SPBIC_RST_REG,
            amp_ctrl: `SPBIC_RST_REG,
            switch_ctrl: `SPBIC_RST_REG,
            ref_dac_code: `SPBIC_RST_REG,
            filter_ctrl: `SPBIC_RST_REG
        },
        gen: spbic_pkg::SPBIC_GEN_IDLE,
        div_cnt: '0,
        idx: '0,
        dac: `SPBIC_DAC_MID,
        stb: 1'b0,
        ack: 1'b0,
        rdata: '0
    };

    spbic_top_st_t q;
    spbic_top_st_t d;

    // Register fields and generator datapath
    logic sine_enable;
    logic bias_divider_enable;
    logic amp_disable_n;
    logic peak_filter_enable;
    logic [DIV_W-1:0] div_last;
    logic [LEN_W-1:0] len_field;
    logic [IDX_W-1:0] half_cycle_samples;
    logic [IDX_W-1:0] full_last;
    logic second_half;
    logic [IDX_W-1:0] pos;
    logic [IDX_W-1:0] gen_addr_lo;
    logic [IDX_W-1:0] gen_addr_hi;
    logic [8:0] sample;
    logic [9:0] sample_code;
    logic [3:0] gain_raw;
    logic [3:0] gain_sel;

    // Bus side
    logic bus_req;
    logic bus_taken;
    logic lane0;
    logic pat_hit;
    logic [IDX_W-1:0] cpu_idx;
    logic [7:0] reg_rd;
    logic [7:0] pat_rd;
    logic ram_wr;
    logic [IDX_W-1:0] ram_addr_a;
    logic [7:0] ram_data_a;
    logic [7:0] ram_data_b;

    assign sine_enable = q.regs.sine_gen_ctrl[`SPBIC_BIT_SINE_EN];
    assign bias_divider_enable =
        q.regs.sine_gen_ctrl[`SPBIC_BIT_BIAS_EN];
    assign amp_disable_n = q.regs.amp_ctrl[`SPBIC_BIT_AMP_DIS_N];
    assign peak_filter_enable =
        q.regs.filter_ctrl[`SPBIC_BIT_FILT_EN];

    // Divider counts 0..N-1 with N = field + 1
    // A field of zero gives one sample on every clock
    assign div_last = q.regs.sine_divider_n[DIV_W-1:0];

    // Half length = field + 1, full cycle = 2 x that
    assign len_field = q.regs.half_cycle_count[LEN_W-1:0];
    assign half_cycle_samples =
        IDX_W'({1'b0, len_field}) + IDX_W'(1);
    assign full_last = {len_field, 1'b1};

    // Second half replays the stored half from its start
    // Lengths changed mid-cycle may give one odd sample, never a stall
    assign second_half = (q.idx >= half_cycle_samples);
    assign pos = second_half ? q.idx - half_cycle_samples : q.idx;

    // Low byte at the even location, bit 8 at the odd one
    // Only bit 0 of the odd byte is used; its upper bits are ignored
    assign gen_addr_lo = {pos[LEN_W-1:0], 1'b0};
    assign gen_addr_hi = {pos[LEN_W-1:0], 1'b1};
    assign sample = {ram_data_b[0], ram_data_a};

    // Mirror about mid-scale: 512+s then 511-s keeps symmetry exact
    always_comb begin
        if (second_half) begin
            sample_code = `SPBIC_DAC_MIRROR - {1'b0, sample};
        end else begin
            sample_code = `SPBIC_DAC_MID + {1'b0, sample};
        end
    end

    // Codes outside 1..10 fall back to unity gain
    assign gain_raw = q.regs.amp_ctrl[3:0];
    always_comb begin
        if (gain_raw == 4'h0 || gain_raw > `SPBIC_GAIN_MAX) begin
            gain_sel = `SPBIC_GAIN_UNITY;
        end else begin
            gain_sel = gain_raw;
        end
    end

    // Bus decode; only byte lane 0 carries data, other lanes are ignored
    // Pattern window: one byte per word, word k maps to pattern byte k
    assign bus_req = avm_req.read | avm_req.write;
    assign bus_taken = bus_req & q.ack;
    assign lane0 = avm_req.byteenable[0];
    assign pat_hit = (avm_req.address[11:8] == `SPBIC_PAT_WIN_PAGE) &&
        (avm_req.address[1:0] == 2'b00);
    assign cpu_idx = avm_req.address[IDX_W+1:2];

    // Unmapped offsets and the pattern window read zero here
    always_comb begin
        case (avm_req.address)
            `SPBIC_OFS_SINE_GEN_CTRL: begin
                reg_rd = q.regs.sine_gen_ctrl;
            end
            `SPBIC_OFS_SINE_DIVIDER_N: begin
                reg_rd = q.regs.sine_divider_n;
            end
            `SPBIC_OFS_HALF_CYCLE_COUNT: begin
                reg_rd = q.regs.half_cycle_count;
            end
            `SPBIC_OFS_AMP_CTRL: begin
                reg_rd = q.regs.amp_ctrl;
            end
            `SPBIC_OFS_SWITCH_CTRL: begin
                reg_rd = q.regs.switch_ctrl;
            end
            `SPBIC_OFS_REF_DAC_CODE: begin
                reg_rd = q.regs.ref_dac_code;
            end
            `SPBIC_OFS_FILTER_CTRL: begin
                reg_rd = q.regs.filter_ctrl;
            end
            default: begin
                reg_rd = 8'h00;
            end
        endcase
    end

    // Generator owns the pattern memory while running
    always_comb begin
        if (pat_hit && !sine_enable) begin
            pat_rd = ram_data_a;
        end else begin
            pat_rd = 8'h00;
        end
    end

    assign ram_wr = bus_taken & avm_req.write & lane0 & pat_hit &
        ~sine_enable;
    // Port a is shared: while running the bus index is ignored, so a CPU
    // access can never disturb the sample being played
    assign ram_addr_a = sine_enable ? gen_addr_lo : cpu_idx;

    // Flop storage read combinationally, so no extra bus wait state
    spbic_pattern_ram #(
        .AW(IDX_W),
        .DEPTH(1 << IDX_W)
    ) u_pattern_ram (
        .clk_sys(clk_sys),
        .srst(srst),
        .wr_en(ram_wr),
        .wr_addr(cpu_idx),
        .wr_data(avm_req.writedata[7:0]),
        .rd_addr_a(ram_addr_a),
        .rd_addr_b(gen_addr_hi),
        .rd_data_a(ram_data_a),
        .rd_data_b(ram_data_b)
    );

    always_comb begin
        d = q;
        d.stb = 1'b0;

        // One wait cycle, then the request completes
        // Read data is captured then and stands until the next read
        if (bus_req && !q.ack) begin
            d.ack = 1'b1;
            if (avm_req.read) begin
                d.rdata = {24'h000000, reg_rd | pat_rd};
            end
        end
        if (bus_taken) begin
            d.ack = 1'b0;
        end

        // Stored masked so unimplemented bits always read zero
        // A write with byte lane 0 off is dropped whole
        if (bus_taken && avm_req.write && lane0) begin
            case (avm_req.address)
                `SPBIC_OFS_SINE_GEN_CTRL: begin
                    d.regs.sine_gen_ctrl = avm_req.writedata[7:0] &
                        `SPBIC_MASK_SINE_GEN_CTRL;
                end
                `SPBIC_OFS_SINE_DIVIDER_N: begin
                    d.regs.sine_divider_n = avm_req.writedata[7:0] &
                        `SPBIC_MASK_SINE_DIVIDER_N;
                end
                `SPBIC_OFS_HALF_CYCLE_COUNT: begin
                    d.regs.half_cycle_count = avm_req.writedata[7:0] &
                        `SPBIC_MASK_HALF_CYCLE_COUNT;
                end
                `SPBIC_OFS_AMP_CTRL: begin
                    d.regs.amp_ctrl = avm_req.writedata[7:0] &
                        `SPBIC_MASK_AMP_CTRL;
                end
                `SPBIC_OFS_SWITCH_CTRL: begin
                    d.regs.switch_ctrl = avm_req.writedata[7:0] &
                        `SPBIC_MASK_SWITCH_CTRL;
                end
                `SPBIC_OFS_REF_DAC_CODE: begin
                    d.regs.ref_dac_code = avm_req.writedata[7:0] &
                        `SPBIC_MASK_REF_DAC_CODE;
                end
                `SPBIC_OFS_FILTER_CTRL: begin
                    // Reserved bit 4 is not stored
                    d.regs.filter_ctrl = avm_req.writedata[7:0] &
                        `SPBIC_MASK_FILTER_CTRL;
                end
                default: begin
                end
            endcase
        end

        // Settings changed while running apply from the next sample on
        case (q.gen)
            spbic_pkg::SPBIC_GEN_IDLE: begin
                // Counters start at zero so playback opens at index 0
                if (sine_enable) begin
                    d.gen = spbic_pkg::SPBIC_GEN_RUN;
                    d.div_cnt = '0;
                    d.idx = '0;
                end
            end
            spbic_pkg::SPBIC_GEN_RUN: begin
                if (!sine_enable) begin
                    // Park at mid-scale one clock after the output powers down
                    d.gen = spbic_pkg::SPBIC_GEN_IDLE;
                    d.dac = `SPBIC_DAC_MID;
                    d.div_cnt = '0;
                    d.idx = '0;
                end else if (q.div_cnt >= div_last) begin
                    // One sample every N clocks, 2 x half per period
                    d.div_cnt = '0;
                    d.dac = sample_code;
                    d.stb = 1'b1;
                    // Compare with >= so a shortened length restarts at once
                    if (q.idx >= full_last) begin
                        d.idx = '0;
                    end else begin
                        d.idx = q.idx + IDX_W'(1);
                    end
                end else begin
                    d.div_cnt = q.div_cnt + DIV_W'(1);
                end
            end
            default: begin
                d.gen = spbic_pkg::SPBIC_GEN_IDLE;
            end
        endcase
    end

    // Bus answer, registers and generator all share this one reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Waitrequest is only high under a request, so an idle bus sees it low
    always_comb begin
        avm_rsp.waitrequest = bus_req & ~q.ack;
        avm_rsp.readdata = q.rdata;
    end
    assign sine_dac_code = q.dac;
    assign sample_strobe = q.stb;

    // Enables are plain register levels; no power sequencing is done here
    always_comb begin
        analog_ctrl.sine_buffer_amp_en = sine_enable;
        analog_ctrl.sine_dac_en = sine_enable;
        analog_ctrl.bias_divider_en = bias_divider_enable;
        // One bit, when high, powers down all three parts together
        analog_ctrl.meas_amp_a_en = ~amp_disable_n;
        analog_ctrl.diff_amp_en = ~amp_disable_n;
        analog_ctrl.ref_dac_en = ~amp_disable_n;
        // Illegal gain codes already arrive here as unity
        analog_ctrl.diff_gain_sel = gain_sel;
        analog_ctrl.ref_dac_level = q.regs.ref_dac_code[5:0];
        analog_ctrl.meas_switches = q.regs.switch_ctrl;
        analog_ctrl.peak_comparator_en = peak_filter_enable;
        analog_ctrl.peak_pmos_en = peak_filter_enable;
        analog_ctrl.discharge_switch_a =
            q.regs.filter_ctrl[`SPBIC_BIT_DISCH_A];
        analog_ctrl.discharge_switch_b =
            q.regs.filter_ctrl[`SPBIC_BIT_DISCH_B];
    end
endmodule // spbic_top
`default_nettype wire

// >>> spbic_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spbic_monitor #(
    parameter int DIV_W = 6,
    parameter int LEN_W = 5
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire spbic_pkg::spbic_avm_req_t avm_req,
    input wire spbic_pkg::spbic_avm_rsp_t avm_rsp,
    input wire spbic_pkg::spbic_analog_t analog_ctrl,
    input wire logic [9:0] sine_dac_code,
    input wire logic sample_strobe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [11:0] wa;
    logic [7:0] wd;
    logic [DIV_W-1:0] div_q;
    logic [7:0] gap_q;
    logic seen_q;
    // Address of a write that completes this cycle, else a dead address
    assign wa = (avm_req.write && !avm_rsp.waitrequest
        && avm_req.byteenable[0]) ? avm_req.address : 12'hFFF;
    assign wd = avm_req.writedata[7:0];
    // Divider shadow; the gap check assumes it is not rewritten mid-run
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            div_q <= '0;
        end else if (wa == 12'h004) begin
            div_q <= wd[DIV_W-1:0];
        end
        gap_q <= sample_strobe ? 8'h01 : gap_q + 8'h01;
        seen_q <= !srst && analog_ctrl.sine_dac_en
            && (seen_q || sample_strobe);
    end
    property p_bus_answer;
        (avm_req.read || avm_req.write) && avm_rsp.waitrequest |=>
            !avm_rsp.waitrequest
            && (!avm_req.read || avm_rsp.readdata[31:8] == 24'h0);
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer late or upper read bits set");
    property p_idle_code;
        !analog_ctrl.sine_dac_en |=>
            sine_dac_code == 10'h200 && !sample_strobe;
    endproperty
    a_idle_code: assert property (p_idle_code)
        else $error("dac code not parked while disabled");
    property p_strobe_on_change;
        $changed(sine_dac_code) && analog_ctrl.sine_dac_en |-> sample_strobe;
    endproperty
    a_strobe_on_change: assert property (p_strobe_on_change)
        else $error("dac code changed without strobe");
    property p_strobe_gap;
        sample_strobe && seen_q |-> gap_q == div_q + 1;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("sample spacing differs from divider");
    property p_ctrl;
        wa == 12'h000 |=> analog_ctrl.bias_divider_en == $past(wd[4])
            && analog_ctrl.sine_buffer_amp_en == $past(wd[7]);
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("control enables wrong");
    property p_gain;
        wa == 12'h00C |=> analog_ctrl.diff_gain_sel ==
            ($past(wd[3:0]) - 4'h1 < 4'hA ? $past(wd[3:0]) : 4'h0);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain select wrong");
    property p_amp;
        wa == 12'h00C |=> analog_ctrl.ref_dac_en != $past(wd[7])
            && analog_ctrl.meas_amp_a_en != $past(wd[7]);
    endproperty
    a_amp: assert property (p_amp)
        else $error("amplifier enables wrong");
    property p_switch;
        wa == 12'h010 |=> analog_ctrl.meas_switches == $past(wd);
    endproperty
    a_switch: assert property (p_switch)
        else $error("switches wrong");
    property p_filter;
        wa == 12'h018 |=> analog_ctrl.peak_comparator_en == $past(wd[7])
            && analog_ctrl.peak_pmos_en == $past(wd[7])
            && analog_ctrl.discharge_switch_b == $past(wd[1])
            && analog_ctrl.discharge_switch_a == $past(wd[0]);
    endproperty
    a_filter: assert property (p_filter)
        else $error("filter controls wrong");
endmodule // spbic_monitor
bind spbic_top spbic_monitor #(.DIV_W(DIV_W), .LEN_W(LEN_W)) mon_u (
    .clk_sys(clk_sys), .srst(srst), .avm_req(avm_req), .avm_rsp(avm_rsp),
    .analog_ctrl(analog_ctrl), .sine_dac_code(sine_dac_code),
    .sample_strobe(sample_strobe));
`default_nettype wire

// >>> spbic_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module spbic_analog_model (
    input wire logic clk_sys,
    input wire spbic_pkg::spbic_analog_t analog_ctrl,
    input wire logic [9:0] sine_dac_code,
    input wire logic sample_strobe
);
    logic [9:0] cap_q [0:63];
    int cnt_q = 0;
    // A powered-down DAC converts nothing, so such strobes are lost
    always @(posedge clk_sys) begin
        if (sample_strobe && analog_ctrl.sine_dac_en
            && cnt_q < 64) begin
            cap_q[cnt_q] <= sine_dac_code;
            cnt_q <= cnt_q + 1;
        end
    end
endmodule // spbic_analog_model
`default_nettype wire

// >>> sine_pattern_bioimpedance_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sine_pattern_bioimpedance_ctrl_bench;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    spbic_pkg::spbic_avm_req_t req = '0;
    spbic_pkg::spbic_avm_rsp_t rsp;
    spbic_pkg::spbic_analog_t ana;
    logic [9:0] dac;
    logic stb;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int base;
    logic [31:0] rd;
    logic [9:0] exp_code;
    logic [8:0] pat [0:3] = '{9'h000, 9'h155, 9'h1FF, 9'h0AA};
    logic [7:0] mask [0:6] = '{8'h90, 8'h3F, 8'h1F, 8'h8F, 8'hFF, 8'h3F,
        8'h83};
    logic [7:0] sw [0:2] = '{8'hC1, 8'h32, 8'h0E};

    initial forever #50 clk_sys = ~clk_sys;

    spbic_top dut_u (.clk_sys(clk_sys), .srst(srst), .avm_req(req),
        .avm_rsp(rsp), .analog_ctrl(ana), .sine_dac_code(dac),
        .sample_strobe(stb));
    spbic_analog_model model_u (.clk_sys(clk_sys), .analog_ctrl(ana),
        .sine_dac_code(dac), .sample_strobe(stb));

    task automatic chk(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // Starts one edge late so a release and a new request never share a step
    task automatic bus(input logic wr, input logic [11:0] a,
        input logic [7:0] d);
        @(posedge clk_sys);
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.byteenable <= 4'h1;
        req.writedata <= {24'h0, d};
        @(posedge clk_sys);
        // Ends when waitrequest drops; no local limit, so only the bench timeout ends a hung wait
        while (rsp.waitrequest) begin
            @(posedge clk_sys);
        end
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 12'(4 * i), 8'h00);
            chk("reset value", 32'h0, rd);
        end
        chk("amp enables", 32'h1, {31'h0, ana.meas_amp_a_en
            && ana.diff_amp_en && ana.ref_dac_en});
        chk("idle code", 32'h200, {22'h0, dac});
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, 12'(4 * i), (i == 6) ? 8'hEF : 8'hFF);
            bus(1'b0, 12'(4 * i), 8'h00);
            chk("masked readback", {24'h0, mask[i]}, rd);
            bus(1'b1, 12'(4 * i), 8'h00);
        end
        bus(1'b1, 12'h01C, 8'hFF);
        bus(1'b0, 12'h01C, 8'h00);
        chk("unmapped read", 32'h0, rd);
        $display("test access done");
        for (int g = 0; g < 16; g++) begin
            bus(1'b1, 12'h00C, 8'(g + 128 * (g % 2)));
            @(posedge clk_sys);
            chk("gain", (g >= 1 && g <= 10) ? g : 0,
                {28'h0, ana.diff_gain_sel});
            chk("amp on", 32'(g % 2 == 0), {31'h0, ana.diff_amp_en});
        end
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 12'h010, sw[i]);
            @(posedge clk_sys);
            chk("switches", {24'h0, sw[i]}, {24'h0, ana.meas_switches});
        end
        bus(1'b1, 12'h018, 8'h82);
        bus(1'b1, 12'h014, 8'h2A);
        bus(1'b1, 12'h000, 8'h10);
        @(posedge clk_sys);
        chk("filter", 32'h6, {29'h0, ana.peak_comparator_en,
            ana.discharge_switch_b, ana.discharge_switch_a});
        chk("ref level", 32'h2A, {26'h0, ana.ref_dac_level});
        chk("bias", 32'h2, {30'h0, ana.bias_divider_en,
            ana.sine_dac_en});
        $display("test analog done");
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 12'(256 + 8 * k), pat[k][7:0]);
            bus(1'b1, 12'(260 + 8 * k), {7'h0, pat[k][8]});
        end
        bus(1'b1, 12'h004, 8'h02);
        bus(1'b1, 12'h008, 8'h03);
        bus(1'b0, 12'h108, 8'h00);
        chk("pattern readback", 32'h55, rd);
        base = model_u.cnt_q;
        bus(1'b1, 12'h000, 8'h80);
        bus(1'b1, 12'h100, 8'h77);
        bus(1'b0, 12'h108, 8'h00);
        chk("blocked read", 32'h0, rd);
        while (model_u.cnt_q < base + 17) begin
            @(posedge clk_sys);
        end
        bus(1'b1, 12'h000, 8'h00);
        // Eight samples per cycle; the seventeenth shows the wrap
        for (int i = 0; i < 17; i++) begin
            exp_code = (i % 8 < 4) ? 10'h200 + pat[i % 4]
                : 10'h1FF - pat[i % 4];
            chk("dac sample", {22'h0, exp_code},
                {22'h0, model_u.cap_q[base + i]});
        end
        repeat (3) @(posedge clk_sys);
        chk("idle code", 32'h200, {22'h0, dac});
        bus(1'b0, 12'h100, 8'h00);
        chk("dropped write", 32'h0, rd);
        $display("test sine done");
        results();
    end
endmodule // sine_pattern_bioimpedance_ctrl_bench
`default_nettype wire
